// File: verilog/uart_host_map.vh
// Register offsets, field positions, reset values and trigger levels
// Assumes inclusion by the channel core, which passes its FIFO sizes to the FIFO
`ifndef UART_HOST_MAP_VH
`define UART_HOST_MAP_VH
// ==========================================
// Offsets
`define OFS_DATA         3'h0
`define OFS_IRQ_ENABLE   3'h1
`define OFS_QUEUE        3'h2
`define OFS_LINE_CTRL    3'h3
`define OFS_MODEM_CTRL   3'h4
`define OFS_LINE_STATUS  3'h5
`define OFS_MODEM_STATUS 3'h6
`define OFS_SCRATCH      3'h7
`define OFS_EFR          3'h2
`define OFS_RESUME_1     3'h4
`define OFS_RESUME_2     3'h5
`define OFS_PAUSE_1      3'h6
`define OFS_PAUSE_2      3'h7
// ==========================================
// Fields and values
`define ENHANCED_KEY     8'hbf
`define LCR_DLAB_BIT     7
`define QC_ENABLE_BIT    0
`define QC_RX_RESET_BIT  1
`define QC_TX_RESET_BIT  2
`define QC_MODE_BIT      3
`define EFR_UNLOCK_BIT   4
`define IE_RX_BIT        0
`define IE_TX_BIT        1
`define IE_LINE_BIT      2
`define IE_MODEM_BIT     3
`define IE_RTS_BIT       6
`define IE_CTS_BIT       7
`define RESET_BYTE       8'h00
`define SCRATCH_RESET    8'hff
// ==========================================
// FIFO and trigger levels
`define FIFO_DEPTH       64
`define FIFO_AW          6
`define CNT_W            7
`define RX_TRIG_0        7'h08
`define RX_TRIG_1        7'h10
`define RX_TRIG_2        7'h38
`define RX_TRIG_3        7'h3c
`define TX_TRIG_0        7'h08
`define TX_TRIG_1        7'h10
`define TX_TRIG_2        7'h20
`define TX_TRIG_3        7'h38
// ==========================================
// Receiver timing in 16x ticks
`define START_SAMPLE     4'h7
`define BIT_TICKS        4'hf
`endif

// File: verilog/uart_host_fifo.v
// Synchronous FIFO with occupancy count, valid/ready both sides
// Assumes one clock; flush clears pointers and count
module uart_host_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 64,
  parameter AW    = 6
) (
  input  wire             clk_in,
  input  wire             reset_in,
  input  wire             flush_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in,
  output wire [AW:0]      count_out
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wp_reg;
  reg [AW-1:0]    rp_reg;
  reg [AW:0]      cnt_reg;
  wire push = wr_valid_in && wr_ready_out;
  wire pop  = rd_valid_out && rd_ready_in;
  assign wr_ready_out = (cnt_reg != DEPTH[AW:0]);
  assign rd_valid_out = (cnt_reg != {(AW+1){1'b0}});
  assign rd_data_out  = mem_reg[rp_reg];
  assign count_out    = cnt_reg;
  always @(posedge clk_in) begin
    if (push)
      mem_reg[wp_reg] <= wr_data_in;
  end
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else if (flush_in) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wp_reg <= wp_reg + 1'b1;
      if (pop)
        rp_reg <= rp_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule // uart_host_fifo

// File: verilog/uart_channel_host.v
// Host side of one UART channel: register banks, FIFOs, start check, ready pins
// Assumes a synchronous host strobe bus and a 16x tick from the baud generator
`include "uart_host_map.vh"
// Notes on behaviour
// - Enhanced bank only when line_ctrl is bf
// - Divisor bank only when line_ctrl bit7 set
// - Ready-status byte selected by own chip select
// - Host write loads tx holding if space
// - Tx holding empty flag means free space
// - Each rx holding read pops oldest character
// - Start bit checked on the eighth tick
// - Rx interrupt follows trigger level with hysteresis-free compare
// - Status source shows rx trigger while at or above
// - Data present while rx FIFO not empty
// - Polled mode: status bits serve host
// - Bits 5,6,7: tx empty, all empty, error
// - Tx empty interrupt tracks holding empty, or below tx trigger in mode 1
// - Line interrupt on character into FIFO
// - Enable bits 3-5 stored, reset zero
// - Interrupt on request-to-send falling edge
// - Interrupt on clear-to-send rising edge
// - Mode 0 ready pins follow space/data
// - Mode 1 tx ready while any space
// - Mode 1 rx ready above trigger
// - Queue bit0 gates other queue bits
// - Enhanced bit4 gates extended enable bits
// - Rx trigger 8,16,56,60
// - Tx trigger 8,16,32,56
module uart_channel_host (
  input  wire       clk_in,
  input  wire       reset_in,
  input  wire       cs_n_in,
  input  wire       ready_status_select_n_in,
  input  wire       rd_n_in,
  input  wire       wr_n_in,
  input  wire [2:0] addr_in,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg        data_oe_out,
  input  wire [2:0] other_rx_ready_n_in,
  input  wire [2:0] other_tx_ready_n_in,
  input  wire       tick16_in,
  input  wire       rx_line_in,
  input  wire       cts_n_in,
  output reg  [7:0] tx_data_out,
  output reg        tx_valid_out,
  input  wire       tx_shifter_ready_in,
  input  wire       tx_shifter_idle_in,
  output reg        start_valid_out,
  input  wire [7:0] rx_char_in,
  input  wire       rx_char_valid_in,
  input  wire [3:0] rx_error_in,
  output reg        rts_n_out,
  output reg        irq_out,
  output reg        tx_ready_n_out,
  output reg        rx_ready_n_out
);
  // ==========================================
  // Registers
  reg [7:0] line_ctrl_reg;
  reg [7:0] irq_enable_reg;
  reg [7:0] queue_ctrl_reg;
  reg [7:0] modem_ctrl_reg;
  reg [7:0] scratch_reg;
  reg [7:0] enhanced_feature_ctrl_reg;
  reg [7:0] resume_char_1_reg;
  reg [7:0] resume_char_2_reg;
  reg [7:0] pause_char_1_reg;
  reg [7:0] pause_char_2_reg;
  reg [7:0] div_low_reg;
  reg [7:0] div_high_reg;
  reg [3:0] line_err_reg;
  reg       fifo_err_reg;
  reg       line_irq_reg;
  reg       rts_irq_reg;
  reg       cts_irq_reg;
  reg       cts_prev_reg;
  reg       rd_prev_reg;
  reg       wr_prev_reg;
  reg [1:0] rx_state_reg;
  reg [3:0] tick_cnt_reg;
  reg       rx_prev_reg;
  // ==========================================
  // Decode
  wire sel      = !cs_n_in;
  wire rd_edge  = sel && !rd_n_in && rd_prev_reg;
  wire wr_edge  = sel && !wr_n_in && wr_prev_reg;
  wire enh_bank = (line_ctrl_reg == `ENHANCED_KEY);
  wire div_bank = line_ctrl_reg[`LCR_DLAB_BIT] && !enh_bank;
  wire fifo_on  = queue_ctrl_reg[`QC_ENABLE_BIT];
  wire unlock   = enhanced_feature_ctrl_reg[`EFR_UNLOCK_BIT];
  // ==========================================
  // FIFOs
  wire [`CNT_W-1:0] tx_count;
  wire [`CNT_W-1:0] rx_count;
  wire [7:0]        rx_head;
  wire              tx_space;
  wire              tx_has;
  wire              rx_has;
  wire [7:0]        tx_head;
  wire              rx_space;
  wire wr_data = wr_edge && addr_in == `OFS_DATA && !div_bank && !enh_bank;
  wire rd_data = rd_edge && addr_in == `OFS_DATA && !div_bank && !enh_bank;
  wire qc_wr   = wr_edge && addr_in == `OFS_QUEUE && !enh_bank && !div_bank
                 && data_in[`QC_ENABLE_BIT];
  wire tx_pop  = tx_has && tx_shifter_ready_in && !tx_valid_out;
  uart_host_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) tx_fifo (
    .clk_in       (clk_in),
    .reset_in     (reset_in),
    .flush_in     (qc_wr && data_in[`QC_TX_RESET_BIT]),
    .wr_data_in   (data_in),
    .wr_valid_in  (wr_data),
    .wr_ready_out (tx_space),
    .rd_data_out  (tx_head),
    .rd_valid_out (tx_has),
    .rd_ready_in  (tx_pop),
    .count_out    (tx_count)
  );
  uart_host_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) rx_fifo (
    .clk_in       (clk_in),
    .reset_in     (reset_in),
    .flush_in     (qc_wr && data_in[`QC_RX_RESET_BIT]),
    .wr_data_in   (rx_char_in),
    .wr_valid_in  (rx_char_valid_in),
    .wr_ready_out (rx_space),
    .rd_data_out  (rx_head),
    .rd_valid_out (rx_has),
    .rd_ready_in  (rd_data),
    .count_out    (rx_count)
  );
  // ==========================================
  // Triggers and status
  reg [`CNT_W-1:0] rx_trig;
  reg [`CNT_W-1:0] tx_trig;
  always @* begin
    case (queue_ctrl_reg[7:6])
      2'h0:    rx_trig = `RX_TRIG_0;
      2'h1:    rx_trig = `RX_TRIG_1;
      2'h2:    rx_trig = `RX_TRIG_2;
      default: rx_trig = `RX_TRIG_3;
    endcase
    case (queue_ctrl_reg[5:4])
      2'h0:    tx_trig = `TX_TRIG_0;
      2'h1:    tx_trig = `TX_TRIG_1;
      2'h2:    tx_trig = `TX_TRIG_2;
      default: tx_trig = `TX_TRIG_3;
    endcase
  end
  // Without FIFOs the flags track empty/not empty; all 64 FIFO slots still fill
  wire rx_trig_hit = fifo_on ? (rx_count >= rx_trig) : rx_has;
  wire thr_empty   = fifo_on ? tx_space : !tx_has;
  wire tx_below    = fifo_on ? (tx_count < tx_trig) : !tx_has;
  wire tx_all_idle = !tx_has && !tx_valid_out && tx_shifter_idle_in;
  wire [7:0] line_status = {fifo_err_reg, tx_all_idle, !tx_has,
                            line_err_reg, rx_has};
  wire rx_irq  = irq_enable_reg[`IE_RX_BIT] && rx_trig_hit;
  wire tx_irq  = irq_enable_reg[`IE_TX_BIT] && (queue_ctrl_reg[`QC_MODE_BIT] && fifo_on
                 ? tx_below : thr_empty);
  wire ln_irq  = irq_enable_reg[`IE_LINE_BIT] && line_irq_reg;
  wire rts_irq = irq_enable_reg[`IE_RTS_BIT] && rts_irq_reg;
  wire cts_irq = irq_enable_reg[`IE_CTS_BIT] && cts_irq_reg;
  reg [7:0] source;
  always @* begin
    source = 8'h01;
    if (ln_irq)
      source = 8'h06;
    else if (rx_irq)
      source = 8'h04;
    else if (tx_irq)
      source = 8'h02;
    else if (rts_irq || cts_irq)
      source = 8'h20;
    if (fifo_on)
      source = source | 8'hc0;
  end
  // ==========================================
  // Read mux
  reg [7:0] rd_val;
  always @* begin
    rd_val = 8'h00;
    if (enh_bank) begin
      case (addr_in)
        `OFS_EFR:      rd_val = enhanced_feature_ctrl_reg;
        `OFS_RESUME_1: rd_val = resume_char_1_reg;
        `OFS_RESUME_2: rd_val = resume_char_2_reg;
        `OFS_PAUSE_1:  rd_val = pause_char_1_reg;
        `OFS_PAUSE_2:  rd_val = pause_char_2_reg;
        `OFS_LINE_CTRL: rd_val = line_ctrl_reg;
        default:       rd_val = 8'h00;
      endcase
    end else if (div_bank && addr_in == `OFS_DATA)
      rd_val = div_low_reg;
    else if (div_bank && addr_in == `OFS_IRQ_ENABLE)
      rd_val = div_high_reg;
    else begin
      case (addr_in)
        `OFS_DATA:         rd_val = rx_head;
        `OFS_IRQ_ENABLE:   rd_val = irq_enable_reg;
        `OFS_QUEUE:        rd_val = source;
        `OFS_LINE_CTRL:    rd_val = line_ctrl_reg;
        `OFS_MODEM_CTRL:   rd_val = modem_ctrl_reg;
        `OFS_LINE_STATUS:  rd_val = line_status;
        `OFS_MODEM_STATUS: rd_val = {!cts_n_in, 7'h00};
        default:           rd_val = scratch_reg;
      endcase
    end
  end
  wire [7:0] ready_byte = {other_rx_ready_n_in, rx_ready_n_out,
                           other_tx_ready_n_in, tx_ready_n_out};
  // ==========================================
  // Start bit check, 16x ticks
  localparam RX_IDLE  = 2'h0;
  localparam RX_CHECK = 2'h1;
  localparam RX_HOLD  = 2'h2;
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_state_reg    <= RX_IDLE;
      tick_cnt_reg    <= 4'h0;
      rx_prev_reg     <= 1'b1;
      start_valid_out <= 1'b0;
    end else begin
      rx_prev_reg     <= rx_line_in;
      start_valid_out <= 1'b0;
      case (rx_state_reg)
        RX_IDLE: if (rx_prev_reg && !rx_line_in) begin
          rx_state_reg <= RX_CHECK;
          tick_cnt_reg <= 4'h0;
        end
        RX_CHECK: if (tick16_in) begin
          tick_cnt_reg <= tick_cnt_reg + 4'h1;
          // Mid-bit sample; a glitch returns to idle as a false start
          if (tick_cnt_reg == `START_SAMPLE) begin
            if (!rx_line_in) begin
              start_valid_out <= 1'b1;
              rx_state_reg    <= RX_HOLD;
            end else
              rx_state_reg <= RX_IDLE;
          end
        end
        RX_HOLD: if (rx_char_valid_in)
          rx_state_reg <= RX_IDLE;
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end
  // ==========================================
  // Register writes and sticky events
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      line_ctrl_reg             <= `RESET_BYTE;
      irq_enable_reg            <= `RESET_BYTE;
      queue_ctrl_reg            <= `RESET_BYTE;
      modem_ctrl_reg            <= `RESET_BYTE;
      scratch_reg               <= `SCRATCH_RESET;
      enhanced_feature_ctrl_reg <= `RESET_BYTE;
      resume_char_1_reg         <= `RESET_BYTE;
      resume_char_2_reg         <= `RESET_BYTE;
      pause_char_1_reg          <= `RESET_BYTE;
      pause_char_2_reg          <= `RESET_BYTE;
      div_low_reg               <= `RESET_BYTE;
      div_high_reg              <= `RESET_BYTE;
      line_err_reg              <= 4'h0;
      fifo_err_reg              <= 1'b0;
      line_irq_reg              <= 1'b0;
      rts_irq_reg               <= 1'b0;
      cts_irq_reg               <= 1'b0;
      cts_prev_reg              <= 1'b0;
      rd_prev_reg               <= 1'b1;
      wr_prev_reg               <= 1'b1;
    end else begin
      rd_prev_reg  <= rd_n_in;
      wr_prev_reg  <= wr_n_in;
      cts_prev_reg <= !cts_n_in;
      if (rd_edge && addr_in == `OFS_LINE_STATUS && !enh_bank) begin
        line_err_reg <= 4'h0;
        fifo_err_reg <= 1'b0;
      end
      if (rd_edge && addr_in == `OFS_QUEUE && !enh_bank) begin
        line_irq_reg <= 1'b0;
        rts_irq_reg  <= 1'b0;
        cts_irq_reg  <= 1'b0;
      end
      if (wr_edge) begin
        if (enh_bank) begin
          case (addr_in)
            `OFS_EFR:       enhanced_feature_ctrl_reg <= data_in;
            `OFS_RESUME_1:  resume_char_1_reg <= data_in;
            `OFS_RESUME_2:  resume_char_2_reg <= data_in;
            `OFS_PAUSE_1:   pause_char_1_reg <= data_in;
            `OFS_PAUSE_2:   pause_char_2_reg <= data_in;
            `OFS_LINE_CTRL: line_ctrl_reg <= data_in;
            default:        scratch_reg <= scratch_reg;
          endcase
        end else if (div_bank && addr_in == `OFS_DATA)
          div_low_reg <= data_in;
        else if (div_bank && addr_in == `OFS_IRQ_ENABLE)
          div_high_reg <= data_in;
        else begin
          case (addr_in)
            `OFS_IRQ_ENABLE: irq_enable_reg <= unlock ? data_in
                                 : {irq_enable_reg[7:4], data_in[3:0]};
            `OFS_QUEUE: if (data_in[`QC_ENABLE_BIT])
              queue_ctrl_reg <= unlock ? {data_in[7:3], 3'h1}
                                : {data_in[7:6], queue_ctrl_reg[5:4], data_in[3], 3'h1};
            else
              queue_ctrl_reg <= `RESET_BYTE;
            `OFS_LINE_CTRL:  line_ctrl_reg <= data_in;
            `OFS_MODEM_CTRL: modem_ctrl_reg <= unlock ? data_in
                                 : {modem_ctrl_reg[7:5], data_in[4:0]};
            `OFS_SCRATCH:    scratch_reg <= data_in;
            default:         scratch_reg <= scratch_reg;
          endcase
        end
      end
      // Hardware set wins over a clearing read in the same cycle
      if (rx_char_valid_in) begin
        line_irq_reg <= 1'b1;
        line_err_reg <= line_err_reg | rx_error_in;
        if (rx_error_in != 4'h0)
          fifo_err_reg <= 1'b1;
      end
      if (!modem_ctrl_reg[1] && !rts_n_out)
        rts_irq_reg <= 1'b1;
      if (!cts_n_in && !cts_prev_reg)
        cts_irq_reg <= 1'b1;
    end
  end
  // ==========================================
  // Outputs, all from flip-flops
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      data_out       <= 8'h00;
      data_oe_out    <= 1'b0;
      tx_data_out    <= 8'h00;
      tx_valid_out   <= 1'b0;
      rts_n_out      <= 1'b1;
      irq_out        <= 1'b0;
      tx_ready_n_out <= 1'b1;
      rx_ready_n_out <= 1'b1;
    end else begin
      data_oe_out <= (sel && !rd_n_in) || !ready_status_select_n_in;
      if (!ready_status_select_n_in)
        data_out <= ready_byte;
      else if (rd_edge)
        data_out <= rd_val;
      if (tx_pop) begin
        tx_data_out  <= tx_head;
        tx_valid_out <= 1'b1;
      end else if (tx_shifter_ready_in)
        tx_valid_out <= 1'b0;
      rts_n_out <= !modem_ctrl_reg[1];
      irq_out   <= rx_irq || tx_irq || ln_irq || rts_irq || cts_irq;
      if (fifo_on && queue_ctrl_reg[`QC_MODE_BIT]) begin
        tx_ready_n_out <= !tx_space;
        rx_ready_n_out <= !(rx_count > rx_trig);
      end else begin
        tx_ready_n_out <= !thr_empty;
        rx_ready_n_out <= !rx_has;
      end
    end
  end
endmodule // uart_channel_host

// File: tb/uart_channel_host_assertions.sv
// Port-level properties of the host side of one UART channel
// Assumes binding to uart_channel_host; sees only its ports
module uart_channel_host_assertions (
  input wire       clk_in,
  input wire       reset_in,
  input wire       cs_n_in,
  input wire       ready_status_select_n_in,
  input wire       rd_n_in,
  input wire       rx_line_in,
  input wire [2:0] other_rx_ready_n_in,
  input wire [2:0] other_tx_ready_n_in,
  input wire       tx_shifter_ready_in,
  input wire [7:0] data_out,
  input wire       data_oe_out,
  input wire [7:0] tx_data_out,
  input wire       tx_valid_out,
  input wire       start_valid_out,
  input wire       rts_n_out,
  input wire       irq_out,
  input wire       tx_ready_n_out,
  input wire       rx_ready_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // ==========================================
  // Sequences
  sequence s_read_taken;
    !cs_n_in && !rd_n_in && $past(rd_n_in);
  endsequence
  sequence s_one_pulse;
    start_valid_out ##1 !start_valid_out;
  endsequence
  sequence s_unselected;
    cs_n_in && ready_status_select_n_in ##1 cs_n_in && ready_status_select_n_in;
  endsequence
  // ==========================================
  // Properties
  a_start_pulse: assert property (start_valid_out |-> s_one_pulse)
    else $error("start pulse longer than one cycle");
  a_start_low: assert property (start_valid_out |->
    !$past(rx_line_in) || !$past(rx_line_in, 2) || !$past(rx_line_in, 3))
    else $error("start accepted on a high line");
  a_tx_hold: assert property (tx_valid_out && !tx_shifter_ready_in |=>
    tx_valid_out && $stable(tx_data_out))
    else $error("tx character dropped before handshake");
  a_ready_byte: assert property (!ready_status_select_n_in |=>
    data_out == {$past(other_rx_ready_n_in), $past(rx_ready_n_out),
                 $past(other_tx_ready_n_in), $past(tx_ready_n_out)})
    else $error("ready byte wrong");
  a_read_drives: assert property (s_read_taken |=> data_oe_out)
    else $error("read not driven");
  a_bus_released: assert property (s_unselected |=> !data_oe_out)
    else $error("bus driven while unselected");
  a_data_stands: assert property (rd_n_in && $past(rd_n_in) &&
    ready_status_select_n_in && $past(ready_status_select_n_in) |-> $stable(data_out))
    else $error("read data changed without a read");
  a_reset_pins: assert property ($fell(reset_in) |-> rts_n_out && !irq_out &&
    tx_ready_n_out && rx_ready_n_out && !tx_valid_out)
    else $error("outputs not at reset levels");
endmodule // uart_channel_host_assertions

bind uart_channel_host uart_channel_host_assertions chk (
  .clk_in(clk_in), .reset_in(reset_in), .cs_n_in(cs_n_in),
  .ready_status_select_n_in(ready_status_select_n_in), .rd_n_in(rd_n_in),
  .rx_line_in(rx_line_in), .other_rx_ready_n_in(other_rx_ready_n_in),
  .other_tx_ready_n_in(other_tx_ready_n_in), .tx_shifter_ready_in(tx_shifter_ready_in),
  .data_out(data_out), .data_oe_out(data_oe_out), .tx_data_out(tx_data_out),
  .tx_valid_out(tx_valid_out), .start_valid_out(start_valid_out), .rts_n_out(rts_n_out),
  .irq_out(irq_out), .tx_ready_n_out(tx_ready_n_out), .rx_ready_n_out(rx_ready_n_out)
);

// File: tb/host_cpu_model.sv
// Host CPU model: masters the channel's strobe bus
// Assumes strobes are sampled on rising edges of clk_in
module host_cpu_model (
  input  wire        clk_in,
  input  wire  [7:0] rdata_in,
  output logic       cs_n_out,
  output logic       sel_n_out,
  output logic       rd_n_out,
  output logic       wr_n_out,
  output logic [2:0] addr_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cs_n_out, sel_n_out, rd_n_out, wr_n_out} = 4'hf;
    addr_out = 3'h0;
    wdata_out = 8'h00;
  end
  // ==========================================
  // One access; strobe held three edges, then high one edge
  task cyc(input logic w, input logic s, input logic [2:0] a, input logic [7:0] d,
           output logic [7:0] q);
    @(posedge clk_in);
    cs_n_out <= s;
    sel_n_out <= !s;
    rd_n_out <= w;
    wr_n_out <= !w;
    addr_out <= a;
    wdata_out <= d;
    repeat (2) @(posedge clk_in);
    #1 q = rdata_in;
    @(posedge clk_in);
    {cs_n_out, sel_n_out, rd_n_out, wr_n_out} <= 4'hf;
    // Released bus shows inverted data, never the stale byte
    wdata_out <= ~d;
    @(posedge clk_in);
    #1;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    cyc(1'b1, 1'b0, a, d, q);
  endtask
  task rd(input logic [2:0] a, output logic [7:0] q);
    cyc(1'b0, 1'b0, a, 8'h00, q);
  endtask
  task rdy(output logic [7:0] q);
    cyc(1'b0, 1'b1, 3'h0, 8'h00, q);
  endtask
  task bank(input logic [7:0] v);
    wr(3'h3, v);
  endtask
  task qc(input logic [7:0] v);
    wr(3'h2, v | 8'h01);
  endtask
endmodule // host_cpu_model

// File: tb/uart_channel_host_tb_top.sv
// Self-checking bench for the host side of one UART channel
// Assumes host_cpu_model as bus master and a 16x tick every 4 clocks
module uart_channel_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_in = 0, reset_in = 1, tick16_in = 0, rx_line_in = 1;
  logic       tx_rdy = 0, tx_idle = 1, rx_vld = 0, cts_n = 1, drain = 0;
  logic [2:0] oth_rx = 3'h5, oth_tx = 3'h2;
  logic [7:0] rx_char = 8'h00, q, lv, tx_exp = 8'h00;
  logic [3:0] rx_err = 4'h0;
  logic [1:0] tdiv = 2'h0;
  wire        cs_n, sel_n, rd_n, wr_n, data_oe_out, tx_valid_out, start_valid_out;
  wire        rts_n_out, irq_out, tx_ready_n_out, rx_ready_n_out;
  wire  [2:0] addr;
  wire  [7:0] wdata, data_out, tx_data_out;
  integer     n_fail = 0, num_checks = 0, i, j, k, sv_cnt = 0;
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    tdiv <= tdiv + 2'h1;
    tick16_in <= (tdiv == 2'h3);
  end
  always @(posedge clk_in) if (start_valid_out === 1'b1) sv_cnt <= sv_cnt + 1;
  // Shifter takes every other cycle so held characters get stalled
  always @(posedge clk_in) tx_rdy <= drain && !tx_rdy;
  // Shifter side: each handshake must carry the next byte in order
  always @(posedge clk_in) if (tx_valid_out === 1'b1 && tx_rdy) begin
    chk8(tx_data_out, tx_exp);
    tx_exp <= tx_exp + 8'h01;
  end
  host_cpu_model h (.clk_in(clk_in), .rdata_in(data_out), .cs_n_out(cs_n),
    .sel_n_out(sel_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .addr_out(addr), .wdata_out(wdata));
  uart_channel_host uut (.clk_in(clk_in), .reset_in(reset_in), .cs_n_in(cs_n),
    .ready_status_select_n_in(sel_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(addr),
    .data_in(wdata), .data_out(data_out), .data_oe_out(data_oe_out),
    .other_rx_ready_n_in(oth_rx), .other_tx_ready_n_in(oth_tx), .tick16_in(tick16_in),
    .rx_line_in(rx_line_in), .cts_n_in(cts_n), .tx_data_out(tx_data_out),
    .tx_valid_out(tx_valid_out), .tx_shifter_ready_in(tx_rdy), .tx_shifter_idle_in(tx_idle),
    .start_valid_out(start_valid_out), .rx_char_in(rx_char), .rx_char_valid_in(rx_vld),
    .rx_error_in(rx_err), .rts_n_out(rts_n_out), .irq_out(irq_out),
    .tx_ready_n_out(tx_ready_n_out), .rx_ready_n_out(rx_ready_n_out));
  // ==========================================
  // Compare, wait and stimulus helpers
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wait_irq(input logic e);
    for (k = 0; k < 40 && irq_out !== e; k++) begin
      @(posedge clk_in);
      #1;
    end
    chk1(irq_out, e);
    if (k == 40) stop_test;
  endtask
  task push(input logic [7:0] c, input logic [3:0] e);
    @(posedge clk_in);
    rx_char <= c;
    rx_err <= e;
    rx_vld <= 1'b1;
    @(posedge clk_in);
    rx_vld <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    chk1(irq_out, 1'b0);
    chk1(tx_ready_n_out, 1'b0);
    chk1(rx_ready_n_out, 1'b1);
    h.rd(3'h1, q);
    chk8(q, 8'h00);
    h.rd(3'h5, q);
    chk8(q, 8'h60);
    h.rdy(q);
    chk8(q, 8'hb4);
    h.bank(8'hbf);
    h.rd(3'h2, q);
    chk8(q, 8'h00);
    for (i = 4; i < 8; i++) h.wr(3'(i), 8'h50 + 8'(i));
    for (i = 4; i < 8; i++) begin
      h.rd(3'(i), q);
      chk8(q, 8'h50 + 8'(i));
    end
    h.bank(8'h00);
    h.rd(3'h7, q);
    chk8(q, 8'hff);
    h.bank(8'h80);
    h.wr(3'h1, 8'h33);
    h.rd(3'h1, q);
    chk8(q, 8'h33);
    h.bank(8'h00);
    h.rd(3'h1, q);
    chk8(q, 8'h00);
    h.wr(3'h1, 8'hc0);
    h.rd(3'h1, q);
    chk8(q, 8'h00);
    h.bank(8'hbf);
    h.wr(3'h2, 8'h10);
    h.bank(8'h00);
    h.wr(3'h1, 8'h40);
    h.wr(3'h4, 8'h02);
    chk1(rts_n_out, 1'b0);
    chk1(irq_out, 1'b0);
    h.wr(3'h4, 8'h00);
    wait_irq(1'b1);
    h.rd(3'h2, q);
    chk8(q, 8'h20);
    wait_irq(1'b0);
    oth_rx <= 3'h3;
    oth_tx <= 3'h4;
    h.rdy(q);
    chk8(q, 8'h78);
    h.wr(3'h1, 8'h80);
    cts_n <= 1'b0;
    wait_irq(1'b1);
    h.rd(3'h2, q);
    chk8(q, 8'h20);
    wait_irq(1'b0);
    cts_n <= 1'b1;
    // False start: line back high long before the mid-bit sample
    rx_line_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    rx_line_in <= 1'b1;
    repeat (60) @(posedge clk_in);
    chk8(sv_cnt[7:0], 8'h00);
    rx_line_in <= 1'b0;
    repeat (60) @(posedge clk_in);
    rx_line_in <= 1'b1;
    chk8(sv_cnt[7:0], 8'h01);
    h.wr(3'h1, 8'h04);
    h.qc(8'h00);
    push(8'h41, 4'h4);
    wait_irq(1'b1);
    chk1(rx_ready_n_out, 1'b0);
    h.rd(3'h5, q);
    chk8(q & 8'h9f, 8'h89);
    h.rd(3'h2, q);
    chk8(q, 8'hc6);
    h.rd(3'h0, q);
    chk8(q, 8'h41);
    chk1(rx_ready_n_out, 1'b1);
    h.wr(3'h1, 8'h01);
    for (i = 0; i < 4; i++) begin
      lv = (i == 0) ? 8'd8 : (i == 1) ? 8'd16 : (i == 2) ? 8'd56 : 8'd60;
      h.qc(8'h08 | 8'(i << 6));
      for (j = 0; j < lv; j++) begin
        chk1(irq_out, 1'b0);
        push(8'(j), 4'h0);
      end
      wait_irq(1'b1);
      chk1(rx_ready_n_out, 1'b1);
      h.rd(3'h2, q);
      chk8(q, 8'hc4);
      push(lv, 4'h0);
      chk1(rx_ready_n_out, 1'b0);
      for (j = 0; j <= lv; j++) begin
        h.rd(3'h0, q);
        chk8(q, 8'(j));
        if (j == 1) begin
          wait_irq(1'b0);
          h.rd(3'h2, q);
          chk8(q, 8'hc1);
        end
      end
      h.rd(3'h5, q);
      chk8(q & 8'h01, 8'h00);
    end
    // Shifter stalled: 64 queued, one refused; then drained with stalls
    h.wr(3'h1, 8'h02);
    h.qc(8'h08);
    tx_idle <= 1'b0;
    for (i = 0; i < 65; i++) h.wr(3'h0, 8'(i));
    chk1(tx_valid_out, 1'b0);
    chk1(tx_ready_n_out, 1'b1);
    chk1(irq_out, 1'b0);
    h.rd(3'h5, q);
    chk8(q & 8'h60, 8'h00);
    drain <= 1'b1;
    for (k = 0; k < 400 && tx_exp != 8'd64; k++) @(posedge clk_in);
    tx_idle <= 1'b1;
    repeat (10) @(posedge clk_in);
    chk8(tx_exp, 8'd64);
    if (k == 400) stop_test;
    h.rd(3'h5, q);
    chk8(q & 8'h60, 8'h60);
    chk1(irq_out, 1'b1);
    chk1(tx_ready_n_out, 1'b0);
    h.wr(3'h1, 8'h00);
    h.wr(3'h2, 8'h08);
    h.rd(3'h2, q);
    chk8(q, 8'h01);
    stop_test;
  end
endmodule // uart_channel_host_tb_top
